// [rtl/adc_ctrl_cfg.svh]
// Constants for the converter control block: offsets, field positions, resets, timing.
// Assumes inclusion by bare name from the design modules, the checker and the bench.
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH
`define ADDR_W               4
`define OFF_RESULT_HIGH      4'h0
`define OFF_RESULT_LOW       4'h1
`define OFF_CONTROL_A        4'h2
`define OFF_CONTROL_B        4'h3
`define OFF_WATCHDOG_CTRL    4'h4
`define OFF_OSC_CTRL         4'h5
`define OFF_IRQ_STATUS       4'h6
`define OFF_IRQ_MASK         4'h7
`define SHARED_SEL_BIT       4
`define IDLE_ON_SLEEP_BIT    7
`define SYS_CLK_SRC_LSB      0
`define CA_ON_BIT            0
`define CA_GO_BIT            1
`define CB_CAL_BIT           6
`define CB_JUSTIFY_BIT       7
`define RESET_BYTE           8'h00
`define RESET_PORT_CFG       8'h00
`define CONV_TAD             11
`define POST_WAIT_TAD        2
`define CLOCK_MHZ            100
`define RC_TAD_NS            4000
`define RC_TAD_CYCLES        ((`RC_TAD_NS * `CLOCK_MHZ) / 1000)
`define IRQ_DONE_BIT         0
`define IRQ_W                1
`endif

// [rtl/adc_ctrl_pkg.sv]
// Types for the converter control block.
// Assumes the constants header sits beside it.
package adc_ctrl_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DELAY,
      ST_ACQUIRE,
      ST_CONVERT,
      ST_WAIT
   } conv_state_t;
endpackage : adc_ctrl_pkg

// [rtl/tad_clock_gen.sv]
// Conversion clock tick generator: oscillator divisor or internal RC source.
// Assumes the oscillator tick and RC enable arrive on the system clock.
`timescale 1ns/100ps
`include "adc_ctrl_cfg.svh"
module tad_clock_gen #(
   parameter int RC_CYCLES = `RC_TAD_CYCLES
) (
   input  wire logic       sys_clk_i,
   input  wire logic       reset_i,
   input  wire logic       run_i,
   input  wire logic       osc_tick_i,
   input  wire logic [2:0] conv_clk_sel_i,
   output logic            tad_tick_o
);
   logic [6:0]  div_cnt;
   logic [15:0] rc_cnt;
   logic [6:0]  divisor;

   // Low two bits pick the power of four, bit 2 doubles it; x11 is the RC source.
   always_comb begin
      divisor = 7'd2 << {conv_clk_sel_i[1:0], conv_clk_sel_i[2]};
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i || !run_i) begin
         div_cnt    <= 7'h00;
         rc_cnt     <= 16'h0000;
         tad_tick_o <= 1'b0;
      end else if (conv_clk_sel_i[1:0] == 2'b11) begin
         // The RC source keeps running while the oscillator is stopped in sleep.
         tad_tick_o <= (rc_cnt == 16'(RC_CYCLES - 1));
         rc_cnt     <= (rc_cnt == 16'(RC_CYCLES - 1)) ? 16'h0000 : rc_cnt + 16'h0001;
      end else begin
         tad_tick_o <= 1'b0;
         if (osc_tick_i) begin
            if (div_cnt == divisor - 7'd1) begin
               div_cnt    <= 7'h00;
               tad_tick_o <= 1'b1;
            end else begin
               div_cnt <= div_cnt + 7'd1;
            end
         end
      end
   end
endmodule : tad_clock_gen

// [rtl/tad_counter.sv]
// Counts conversion clock ticks down from a load value and flags the last one.
// Assumes ticks are one-cycle pulses on the system clock.
`timescale 1ns/100ps
module tad_counter (
   input  wire logic       sys_clk_i,
   input  wire logic       reset_i,
   input  wire logic       load_i,
   input  wire logic [4:0] load_val_i,
   input  wire logic       tick_i,
   output logic            expire_o
);
   logic [4:0] remaining;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         remaining <= 5'h00;
         expire_o  <= 1'b0;
      end else if (load_i) begin
         remaining <= load_val_i;
         expire_o  <= 1'b0;
      end else begin
         expire_o <= tick_i && (remaining == 5'd1);
         if (tick_i && remaining != 5'd0) begin
            remaining <= remaining - 5'd1;
         end
      end
   end
endmodule : tad_counter

// [rtl/adc_power_mode_control.sv]
// Converter control: register file with shared-address overlay, conversion sequencer,
// calibration, result registers and conversion-done interrupt.
// Assumes a synchronous register port, an oscillator tick and an analog sample bus.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "adc_ctrl_cfg.svh"
import adc_ctrl_pkg::*;

module adc_power_mode_control #(
   parameter int ADDR_W      = `ADDR_W,
   parameter int INSTR_CYCLES = 4
) (
   input  wire logic              sys_clk_i,
   input  wire logic              reset_i,
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   input  wire logic              reg_write_i,
   input  wire logic              reg_read_i,
   input  wire logic              osc_tick_i,
   input  wire logic              sleeping_i,
   input  wire logic [9:0]        sample_data_i,
   output logic [7:0]             reg_rdata_o,
   output logic [3:0]             channel_sel_o,
   output logic                   sampling_o,
   output logic [15:0]            analog_en_o,
   output logic                   irq_o
);
   logic [7:0]  result_high_byte;
   logic [7:0]  result_low_byte;
   logic [7:0]  converter_control_a;
   logic [7:0]  converter_control_b;
   logic [7:0]  analog_port_config_low;
   logic [7:0]  analog_port_config_high;
   logic [7:0]  watchdog_control_reg;
   logic [7:0]  oscillator_control_reg;
   logic [7:0]  irq_status;
   logic [7:0]  irq_mask;
   logic [9:0]  offset_trim;
   logic [7:0]  delay_cnt;
   conv_state_t state;
   logic        shared_reg_select;
   logic        converter_on;
   logic        go_flag;
   logic        offset_cal_request;
   logic [2:0]  acq_time_sel;
   logic [2:0]  conv_clk_sel;
   logic        result_justify;
   logic        tad_tick;
   logic        tad_expire;
   logic        cnt_load;
   logic [4:0]  cnt_val;
   logic        conv_done;
   logic        cal_run;
   logic [9:0]  corrected;
   logic [9:0]  raw_sample;
   logic        wr_a;
   logic        wr_b;
   logic        wr_analog_port_config_low;
   logic        wr_analog_port_config_high;

   assign shared_reg_select  = watchdog_control_reg[`SHARED_SEL_BIT];
   assign converter_on       = converter_control_a[`CA_ON_BIT];
   assign go_flag            = converter_control_a[`CA_GO_BIT];
   assign offset_cal_request = converter_control_b[`CB_CAL_BIT];
   assign result_justify     = converter_control_b[`CB_JUSTIFY_BIT];
   assign acq_time_sel       = converter_control_b[5:3];
   assign conv_clk_sel       = converter_control_b[2:0];

   // Acquisition field: 000 is none, otherwise 2, 4, 6, 8, 12, 16, 20 periods.
   function automatic logic [4:0] acq_periods(input logic [2:0] sel);
      unique case (sel)
         3'b000: acq_periods = 5'd0;
         3'b001: acq_periods = 5'd2;
         3'b010: acq_periods = 5'd4;
         3'b011: acq_periods = 5'd6;
         3'b100: acq_periods = 5'd8;
         3'b101: acq_periods = 5'd12;
         3'b110: acq_periods = 5'd16;
         3'b111: acq_periods = 5'd20;
      endcase
   endfunction : acq_periods

   function automatic logic shared_hit(input logic [ADDR_W-1:0] a);
      shared_hit = (a == `OFF_CONTROL_A) || (a == `OFF_CONTROL_B);
   endfunction : shared_hit

   // Only the register visible under the select bit takes a write.
   assign wr_a      = reg_write_i && reg_addr_i == `OFF_CONTROL_A && !shared_reg_select;
   assign wr_b      = reg_write_i && reg_addr_i == `OFF_CONTROL_B && !shared_reg_select;
   assign wr_analog_port_config_low = reg_write_i && reg_addr_i == `OFF_CONTROL_A && shared_reg_select;
   assign wr_analog_port_config_high = reg_write_i && reg_addr_i == `OFF_CONTROL_B && shared_reg_select;

   tad_clock_gen u_tad_clock_gen (
      .sys_clk_i      (sys_clk_i),
      .reset_i        (reset_i),
      .run_i          (state != ST_IDLE),
      .osc_tick_i     (osc_tick_i && !sleeping_i),
      .conv_clk_sel_i (conv_clk_sel),
      .tad_tick_o     (tad_tick)
   );

   tad_counter u_tad_counter (
      .sys_clk_i  (sys_clk_i),
      .reset_i    (reset_i),
      .load_i     (cnt_load),
      .load_val_i (cnt_val),
      .tick_i     (tad_tick),
      .expire_o   (tad_expire)
   );

   assign cnt_load  = (state == ST_IDLE) || (state == ST_DELAY) || conv_done ||
                      (state == ST_ACQUIRE && tad_expire);
   // The delay state must preload the conversion length, or a zero acquisition never ends.
   assign cnt_val   = (state == ST_ACQUIRE || state == ST_DELAY) ? 5'(`CONV_TAD) :
                      (state == ST_CONVERT) ? 5'(`POST_WAIT_TAD) : acq_periods(acq_time_sel);
   assign conv_done = (state == ST_CONVERT) && tad_expire;

   // Sequencer. Idle and sleep entry do not reset it; in sleep a running conversion finishes only on the RC source.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state     <= ST_IDLE;
         delay_cnt <= 8'h00;
         cal_run   <= 1'b0;
      end else if (!converter_on || !go_flag) begin
         // Clearing go aborts; the result registers keep the last completed value.
         if (state == ST_IDLE) begin
            cal_run <= 1'b0;
         end
         state <= (state == ST_CONVERT || state == ST_ACQUIRE) ? ST_WAIT :
                  (state == ST_WAIT && tad_expire) ? ST_IDLE :
                  (state == ST_WAIT) ? ST_WAIT : ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               cal_run <= offset_cal_request;
               if (acq_time_sel == 3'b000) begin
                  state     <= ST_DELAY;
                  delay_cnt <= 8'(INSTR_CYCLES - 1);
               end else begin
                  state <= ST_ACQUIRE;
               end
            end
            ST_DELAY: begin
               if (delay_cnt == 8'h00) begin
                  state <= ST_CONVERT;
               end else begin
                  delay_cnt <= delay_cnt - 8'h01;
               end
            end
            ST_ACQUIRE: begin
               if (tad_expire) begin
                  state <= ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (conv_done) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (tad_expire) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // A zero-length acquisition loads no periods, so the delay state waits INSTR_CYCLES clocks, then enters convert.
   assign raw_sample = cal_run ? 10'h000 : sample_data_i;
   assign corrected  = raw_sample - offset_trim;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         offset_trim <= 10'h000;
      end else if (conv_done && cal_run) begin
         offset_trim <= sample_data_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         converter_control_a <= `RESET_BYTE;
      end else if (conv_done) begin
         converter_control_a <= converter_control_a & ~(8'h01 << `CA_GO_BIT);
      end else if (wr_a) begin
         converter_control_a <= reg_wdata_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         converter_control_b  <= `RESET_BYTE;
         analog_port_config_low  <= `RESET_PORT_CFG;
         analog_port_config_high <= `RESET_PORT_CFG;
         watchdog_control_reg    <= `RESET_BYTE;
         oscillator_control_reg  <= `RESET_BYTE;
         irq_mask                <= `RESET_BYTE;
      end else if (reg_write_i) begin
         if (wr_b) begin
            converter_control_b <= reg_wdata_i;
         end
         if (wr_analog_port_config_low) begin
            analog_port_config_low <= reg_wdata_i & 8'h9f;
         end
         if (wr_analog_port_config_high) begin
            analog_port_config_high <= reg_wdata_i & 8'hfc;
         end
         if (reg_addr_i == `OFF_WATCHDOG_CTRL) begin
            watchdog_control_reg <= reg_wdata_i;
         end
         if (reg_addr_i == `OFF_OSC_CTRL) begin
            oscillator_control_reg <= reg_wdata_i;
         end
         if (reg_addr_i == `OFF_IRQ_MASK) begin
            irq_mask <= reg_wdata_i & 8'h01;
         end
      end
   end

   // Software writes take effect, but a completing conversion other than calibration overrides them.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         result_high_byte <= `RESET_BYTE;
         result_low_byte  <= `RESET_BYTE;
      end else if (conv_done && !cal_run) begin
         if (result_justify) begin
            result_high_byte <= {6'h00, corrected[9:8]};
            result_low_byte  <= corrected[7:0];
         end else begin
            result_high_byte <= corrected[9:2];
            result_low_byte  <= {corrected[1:0], 6'h00};
         end
      end else if (reg_write_i) begin
         if (reg_addr_i == `OFF_RESULT_HIGH) begin
            result_high_byte <= reg_wdata_i;
         end
         if (reg_addr_i == `OFF_RESULT_LOW) begin
            result_low_byte <= reg_wdata_i;
         end
      end
   end

   // The set beats a simultaneous write-one clear.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         irq_status <= `RESET_BYTE;
      end else begin
         irq_status[`IRQ_DONE_BIT] <= conv_done || (irq_status[`IRQ_DONE_BIT] &&
            !(reg_write_i && reg_addr_i == `OFF_IRQ_STATUS && reg_wdata_i[`IRQ_DONE_BIT]));
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_status & irq_mask);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_read_i) begin
         if (shared_hit(reg_addr_i) && shared_reg_select) begin
            reg_rdata_o <= (reg_addr_i == `OFF_CONTROL_A) ? analog_port_config_low :
                           analog_port_config_high;
         end else begin
            unique case (reg_addr_i)
               `OFF_RESULT_HIGH:   reg_rdata_o <= result_high_byte;
               `OFF_RESULT_LOW:    reg_rdata_o <= result_low_byte;
               `OFF_CONTROL_A:     reg_rdata_o <= converter_control_a;
               `OFF_CONTROL_B:     reg_rdata_o <= converter_control_b;
               `OFF_WATCHDOG_CTRL: reg_rdata_o <= watchdog_control_reg;
               `OFF_OSC_CTRL:      reg_rdata_o <= oscillator_control_reg;
               `OFF_IRQ_STATUS:    reg_rdata_o <= irq_status;
               `OFF_IRQ_MASK:      reg_rdata_o <= irq_mask;
               default:            reg_rdata_o <= 8'h00;
            endcase
         end
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         channel_sel_o <= 4'h0;
         sampling_o    <= 1'b0;
         analog_en_o   <= 16'h0000;
      end else begin
         channel_sel_o <= converter_control_a[5:2];
         // Sampling resumes in idle; a calibration dummy samples nothing.
         sampling_o    <= converter_on && !cal_run &&
                          (state == ST_IDLE || state == ST_ACQUIRE || state == ST_DELAY);
         analog_en_o   <= ~{analog_port_config_high, analog_port_config_low} & 16'hfc9f;
      end
   end
endmodule : adc_power_mode_control

// [sim/adc_ctrl_assertions.sv]
// Checker for the converter control block, bound to its top module.
// Assumes the offsets and bit positions of the shared constants header.
`timescale 1ns/100ps
`include "adc_ctrl_cfg.svh"
module adc_ctrl_checker #(
   parameter int ADDR_W = 4
) (
   input wire logic              sys_clk_i,
   input wire logic              reset_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0]        reg_wdata_i,
   input wire logic              reg_write_i,
   input wire logic              reg_read_i,
   input wire logic              osc_tick_i,
   input wire logic              sleeping_i,
   input wire logic [9:0]        sample_data_i,
   input wire logic [7:0]        reg_rdata_o,
   input wire logic [3:0]        channel_sel_o,
   input wire logic              sampling_o,
   input wire logic [15:0]       analog_en_o,
   input wire logic              irq_o
);
   default clocking cb_main @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   // Shadow of the overlay select, so each access can be judged by what it should reach.
   logic shared;
   logic wr_a;
   logic wr_b;
   assign wr_a = reg_write_i && (reg_addr_i == `OFF_CONTROL_A);
   assign wr_b = reg_write_i && (reg_addr_i == `OFF_CONTROL_B);
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         shared <= 1'b0;
      end else if (reg_write_i && (reg_addr_i == `OFF_WATCHDOG_CTRL)) begin
         shared <= reg_wdata_i[`SHARED_SEL_BIT];
      end
   end
   property p_rd_idle;
      !$past(reg_read_i) |-> reg_rdata_o == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_unmapped;
      reg_read_i && (reg_addr_i > 4'h7) |=> reg_rdata_o == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_legacy_chan;
      wr_a && !shared |-> ##2 channel_sel_o == $past(reg_wdata_i[5:2], 2);
   endproperty
   a_legacy_chan: assert property (p_legacy_chan) else $error("channel not from control");
   property p_hidden;
      wr_a && shared |=> ##1 $stable(channel_sel_o);
   endproperty
   a_hidden: assert property (p_hidden) else $error("hidden control altered");
   property p_port_cfg;
      (wr_a || wr_b) && !shared |=> ##1 $stable(analog_en_o);
   endproperty
   a_port_cfg: assert property (p_port_cfg) else $error("port config altered");
   property p_mask;
      reg_write_i && (reg_addr_i == `OFF_IRQ_MASK) && !reg_wdata_i[0] |-> ##2 !irq_o;
   endproperty
   a_mask: assert property (p_mask) else $error("masked interrupt still high");
   property p_clear;
      reg_write_i && (reg_addr_i == `OFF_IRQ_STATUS) && reg_wdata_i[0] |-> ##2 !irq_o;
   endproperty
   a_clear: assert property (p_clear) else $error("interrupt not cleared");
   property p_conv_min;
      wr_a && !shared && reg_wdata_i[1] && !irq_o |=> !irq_o [*8];
   endproperty
   a_conv_min: assert property (p_conv_min) else $error("conversion ended too soon");
   property p_status_irq;
      reg_read_i && (reg_addr_i == `OFF_IRQ_STATUS) && irq_o |=> reg_rdata_o[0];
   endproperty
   a_status_irq: assert property (p_status_irq) else $error("irq without status");
   c_conv: cover property ($rose(irq_o));
   c_overlay: cover property (wr_a && shared);
   c_unmapped: cover property (reg_read_i && (reg_addr_i > 4'h7));
endmodule : adc_ctrl_checker

bind adc_power_mode_control adc_ctrl_checker #(.ADDR_W(ADDR_W)) i_adc_ctrl_checker (
   .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
   .osc_tick_i(osc_tick_i), .sleeping_i(sleeping_i), .sample_data_i(sample_data_i),
   .reg_rdata_o(reg_rdata_o), .channel_sel_o(channel_sel_o), .sampling_o(sampling_o),
   .analog_en_o(analog_en_o), .irq_o(irq_o));

// [sim/tb_top.sv]
// Self-checking bench for the converter control block.
// Assumes the register map of the shared constants header and a free-running oscillator tick.
`timescale 1ns/100ps
`include "adc_ctrl_cfg.svh"
module tb_top;
   logic        sys_clk, rst, we, re, tick, sleep, irq, sampling;
   logic [3:0]  addr, chan;
   logic [7:0]  wd, rdata;
   logic [9:0]  sample;
   logic [15:0] aen;
   int          errors, samples_checked;
   logic [7:0]  cbv [9] = '{8'h80, 8'h84, 8'h81, 8'h85, 8'h82, 8'h86, 8'h83, 8'h87, 8'h00};
   int          dv [9] = '{2, 4, 8, 16, 32, 64, 400, 400, 2};

   adc_power_mode_control #(.INSTR_CYCLES(4)) i_adc_power_mode_control (
      .sys_clk_i(sys_clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
      .reg_write_i(we), .reg_read_i(re), .osc_tick_i(tick), .sleeping_i(sleep),
      .sample_data_i(sample), .reg_rdata_o(rdata), .channel_sel_o(chan),
      .sampling_o(sampling), .analog_en_o(aen), .irq_o(irq));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic final_report();
      if (errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      we <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge sys_clk);
      we <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      re <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      re <= 1'b0;
      #1 d = rdata;
   endtask : rd

   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : settle

   // One conversion: measured length, result pair, go flag, interrupt mask and clear.
   task automatic conv(input logic [7:0] cb, input int tad, input logic [9:0] s,
                       input logic [7:0] eh, input logic [7:0] el);
      int n;
      logic [7:0] d;
      wr(`OFF_CONTROL_B, cb);
      sample <= s;
      wr(`OFF_CONTROL_A, 8'h2F);
      n = 0;
      while (irq !== 1'b1 && n < 6000) begin
         @(posedge sys_clk);
         #1 n++;
         if (n == 6) cmp(sampling, 1'b0);
      end
      cmp(n >= 11 * tad + 2 && n <= 12 * tad + 12, 1'b1);
      cmp(chan, 4'hB);
      rd(`OFF_CONTROL_A, d);
      cmp(d[1], 1'b0);
      rd(`OFF_RESULT_HIGH, d);
      cmp(d, eh);
      rd(`OFF_RESULT_LOW, d);
      cmp(d, el);
      wr(`OFF_IRQ_MASK, 8'h00);
      settle();
      cmp(irq, 1'b0);
      rd(`OFF_IRQ_STATUS, d);
      cmp(d[0], 1'b1);
      wr(`OFF_IRQ_MASK, 8'h01);
      settle();
      cmp(irq, 1'b1);
      wr(`OFF_IRQ_STATUS, 8'h01);
      settle();
      cmp(irq, 1'b0);
      repeat (2 * tad + 12) @(posedge sys_clk);
      #1 cmp(sampling, 1'b1);
   endtask : conv

   initial begin
      #300_000;
      errors++;
      final_report();
   end

   initial begin
      logic [7:0] d;
      rst = 1'b1;
      we = 1'b0;
      re = 1'b0;
      addr = 4'h0;
      wd = 8'h00;
      tick = 1'b1;
      sleep = 1'b0;
      sample = 10'h000;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      for (int a = 0; a < 16; a++) begin
         rd(4'(a), d);
         cmp(d, 8'h00);
      end
      // Overlay: port configuration through the shared addresses, legacy copy untouched.
      wr(`OFF_CONTROL_B, 8'h80);
      wr(`OFF_WATCHDOG_CTRL, 8'h10);
      wr(`OFF_CONTROL_A, 8'h9E);
      wr(`OFF_CONTROL_B, 8'h7C);
      rd(`OFF_CONTROL_A, d);
      cmp(d, 8'h9E);
      rd(`OFF_CONTROL_B, d);
      cmp(d, 8'h7C);
      cmp(aen, 16'h8001);
      wr(`OFF_WATCHDOG_CTRL, 8'h00);
      rd(`OFF_CONTROL_B, d);
      cmp(d, 8'h80);
      rd(`OFF_CONTROL_A, d);
      cmp(d, 8'h00);
      wr(`OFF_IRQ_MASK, 8'h01);
      for (int i = 0; i < 9; i++) begin
         wr(`OFF_OSC_CTRL, 8'h00);
         sleep <= (dv[i] == 400);
         conv(cbv[i], dv[i], 10'h2C5, cbv[i][7] ? 8'h02 : 8'hB1, cbv[i][7] ? 8'hC5 : 8'h40);
      end
      sleep <= 1'b0;
      conv(8'hC0, 2, 10'h005, 8'hB1, 8'h40);
      conv(8'h80, 2, 10'h2C5, 8'h02, 8'hC0);
      final_report();
   end
endmodule : tb_top
